//--- rtl/boot_clk_pkg.sv
// Package: register map, field layout and ratio tables of the boot clock word
package boot_clk_pkg;
    // Register byte addresses
    localparam logic [3:0]  CFG_WORD_OFFSET   = 4'h0;
    localparam logic [3:0]  CTRL_OFFSET       = 4'h4;
    localparam logic [3:0]  STATUS_OFFSET     = 4'h8;
    localparam logic [3:0]  RATIO_OFFSET      = 4'hc;
    // Field positions in the configuration word
    localparam int          ODIV_LSB          = 16;
    localparam int          USB_BYPASS_BIT    = 15;
    localparam int          USB_IDIV_LSB      = 8;
    localparam int          MUL_LSB           = 4;
    localparam int          IDIV_LSB          = 0;
    // Reserved positions that must be programmed as ones
    localparam logic [31:0] RSVD_MASK         = 32'hfff8_7888;
    // Erased non-volatile word, used until a word has been captured
    localparam logic [31:0] CFG_RESET         = 32'hffff_ffff;
    // Answer for an unmapped address
    localparam logic [31:0] UNMAPPED_DATA     = 32'h0000_0000;
    // Status bit positions
    localparam int          ST_VALID_BIT      = 0;
    localparam int          ST_RSVD_ERR_BIT   = 1;
    localparam int          ST_USB_ON_BIT     = 2;
    localparam int          ST_USB_PRESENT_BIT = 3;
    // Read latency of the slave in cycles
    localparam int          READ_WAIT         = 1;

    typedef logic [2:0] sel_type;

    // Output divisor as a shift amount: 1,2,4,8,16,32,64,256
    function automatic logic [3:0] odiv_shift(input sel_type s);
        case (s)
            3'h7:    odiv_shift = 4'h8;
            default: odiv_shift = {1'b0, s};
        endcase
    endfunction : odiv_shift

    // Multiplier ratio: 15..21 then 24
    function automatic logic [4:0] mul_ratio(input sel_type s);
        case (s)
            3'h7:    mul_ratio = 5'h18;
            default: mul_ratio = 5'h0f + {2'h0, s};
        endcase
    endfunction : mul_ratio

    // USB input divider: 1..6 then 10, 12
    function automatic logic [3:0] usb_div_ratio(input sel_type s);
        case (s)
            3'h6:    usb_div_ratio = 4'ha;
            3'h7:    usb_div_ratio = 4'hc;
            default: usb_div_ratio = {1'b0, s} + 4'h1;
        endcase
    endfunction : usb_div_ratio
endpackage : boot_clk_pkg

//--- rtl/cfg_fields_if.sv
// Interface: decoded clock settings passed from decoder to register slave
`timescale 1ns/1ps
interface cfg_fields_if;
    logic        valid;
    logic [8:0]  odiv_ratio_log;
    logic [4:0]  mul_ratio;
    logic        usb_on;
    logic [3:0]  usb_div_ratio;
    logic [2:0]  in_div_sel;
    logic        rsvd_err;
    modport producer (output valid, odiv_ratio_log, mul_ratio, usb_on, usb_div_ratio, in_div_sel, rsvd_err);
    modport consumer (input  valid, odiv_ratio_log, mul_ratio, usb_on, usb_div_ratio, in_div_sel, rsvd_err);
endinterface : cfg_fields_if

//--- rtl/cfg_field_decode.sv
// Decoder: turns the captured configuration word into clock ratios
`timescale 1ns/1ps
module cfg_field_decode #(
    parameter bit HAS_USB = 1'b1
) (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        arst_n,
    // Captured word
    input  wire logic        word_valid,
    input  wire logic [31:0] word,
    // Decoded settings
    cfg_fields_if.producer   fields
);
    logic [8:0] odiv_q;
    logic [4:0] mul_q;
    logic       usb_on_q;
    logic [3:0] usb_div_q;
    logic [2:0] idiv_q;
    logic       rsvd_q;
    logic       valid_q;

    // Registered decode so the ratio outputs never glitch
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            odiv_q    <= 9'h001;
            mul_q     <= 5'h0f;
            usb_on_q  <= 1'b0;
            usb_div_q <= 4'h1;
            idiv_q    <= 3'h0;
            rsvd_q    <= 1'b0;
            valid_q   <= 1'b0;
        end
        else
        begin
            valid_q  <= word_valid;
            odiv_q   <= 9'(9'h001 << boot_clk_pkg::odiv_shift(word[boot_clk_pkg::ODIV_LSB +: 3]));
            mul_q    <= boot_clk_pkg::mul_ratio(word[boot_clk_pkg::MUL_LSB +: 3]);
            // Parts without USB ignore these positions
            usb_on_q <= HAS_USB & ~word[boot_clk_pkg::USB_BYPASS_BIT];
            usb_div_q <= HAS_USB ? boot_clk_pkg::usb_div_ratio(word[boot_clk_pkg::USB_IDIV_LSB +: 3])
                                 : 4'h1;
            idiv_q   <= word[boot_clk_pkg::IDIV_LSB +: 3];
            rsvd_q   <= word_valid & ((word & boot_clk_pkg::RSVD_MASK) != boot_clk_pkg::RSVD_MASK);
        end
    end

    assign fields.valid          = valid_q;
    assign fields.odiv_ratio_log = odiv_q;
    assign fields.mul_ratio      = mul_q;
    assign fields.usb_on         = usb_on_q;
    assign fields.usb_div_ratio  = usb_div_q;
    assign fields.in_div_sel     = idiv_q;
    assign fields.rsvd_err       = rsvd_q;

    // Checks on decode
    mul_top_a: assert property (@(posedge mclk) disable iff (!arst_n)
        word[6:4] == 3'h7 |=> mul_q == 5'h18) else $error("multiplier 24 not decoded");
    odiv_top_a: assert property (@(posedge mclk) disable iff (!arst_n)
        word[18:16] == 3'h7 |=> odiv_q == 9'h100) else $error("divisor 256 not decoded");
    odiv_one_a: assert property (@(posedge mclk) disable iff (!arst_n)
        word[18:16] == 3'h0 |=> odiv_q == 9'h001) else $error("divisor 1 not decoded");
    usb_div_a: assert property (@(posedge mclk) disable iff (!arst_n)
        HAS_USB && word[10:8] == 3'h6 |=> usb_div_q == 4'ha) else $error("usb divider 10 wrong");
    usb_bypass_a: assert property (@(posedge mclk) disable iff (!arst_n)
        word[15] |=> !usb_on_q) else $error("usb pll on while bypassed");
endmodule : cfg_field_decode

//--- rtl/av_word_slave.sv
// Avalon-MM read-only slave over the three mapped words
`timescale 1ns/1ps
module av_word_slave (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        arst_n,
    // Avalon-MM
    input  wire logic [3:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    // Word sources
    input  wire logic [31:0] word0,
    input  wire logic [31:0] word2,
    input  wire logic [31:0] word3
);
    logic        done_q;
    logic [31:0] rdata_q;

    // One wait state on reads; writes are accepted at once and dropped
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            done_q <= 1'b0;
        else
            done_q <= read & ~done_q;
    end

    // Read mux registered for clean data
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            rdata_q <= 32'h0000_0000;
        else if (read && !done_q)
        begin
            case (address)
                boot_clk_pkg::CFG_WORD_OFFSET: rdata_q <= word0;
                boot_clk_pkg::STATUS_OFFSET:   rdata_q <= word2;
                boot_clk_pkg::RATIO_OFFSET:    rdata_q <= word3;
                default:                       rdata_q <= boot_clk_pkg::UNMAPPED_DATA;
            endcase
        end
    end

    assign waitrequest = read & ~done_q;
    assign readdata    = rdata_q;

    read_wait_a: assert property (@(posedge mclk) disable iff (!arst_n)
        $rose(read) |-> waitrequest ##1 !waitrequest) else $error("read latency not one wait");
    write_fast_a: assert property (@(posedge mclk) disable iff (!arst_n)
        write |-> !waitrequest) else $error("write stalled");
    rd_cov: cover property (@(posedge mclk) disable iff (!arst_n) read && !waitrequest);
    wr_cov: cover property (@(posedge mclk) disable iff (!arst_n) write);
endmodule : av_word_slave

//--- rtl/boot_clock_cfg.sv
// Top: boot clock configuration capture, decode and register access
`timescale 1ns/1ps
module boot_clock_cfg #(
    parameter bit HAS_USB = 1'b1
) (
    // Clock and reset
    mclk,
    arst_n,
    // Non-volatile word at power-up
    nv_word,
    nv_word_valid,
    // Avalon-MM slave
    address,
    read,
    write,
    writedata,
    readdata,
    waitrequest,
    // Clock settings out
    cfg_ready,
    pll_output_divisor_sel,
    pll_multiplier_sel,
    pll_input_divisor_sel,
    usb_pll_bypass,
    usb_pll_input_div_sel,
    pll_mul_ratio,
    pll_out_div_ratio,
    usb_pll_div_ratio,
    usb_pll_enable,
    rsvd_error
);
    input  wire logic        mclk;
    input  wire logic        arst_n;
    input  wire logic [31:0] nv_word;
    input  wire logic        nv_word_valid;
    input  wire logic [3:0]  address;
    input  wire logic        read;
    input  wire logic        write;
    input  wire logic [31:0] writedata;
    output logic      [31:0] readdata;
    output logic             waitrequest;
    output logic             cfg_ready;
    output logic      [2:0]  pll_output_divisor_sel;
    output logic      [2:0]  pll_multiplier_sel;
    output logic      [2:0]  pll_input_divisor_sel;
    output logic             usb_pll_bypass;
    output logic      [2:0]  usb_pll_input_div_sel;
    output logic      [4:0]  pll_mul_ratio;
    output logic      [8:0]  pll_out_div_ratio;
    output logic      [3:0]  usb_pll_div_ratio;
    output logic             usb_pll_enable;
    output logic             rsvd_error;

    cfg_fields_if fields ();

    logic [31:0] word_q;
    logic        captured_q;

    // One-time capture: later strobes are ignored, the word is fixed till reset
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            word_q     <= boot_clk_pkg::CFG_RESET;
            captured_q <= 1'b0;
        end
        else if (nv_word_valid && !captured_q)
        begin
            word_q     <= nv_word;
            captured_q <= 1'b1;
        end
    end

    cfg_field_decode #(.HAS_USB(HAS_USB)) u_dec (
        .mclk       (mclk),
        .arst_n     (arst_n),
        .word_valid (captured_q),
        .word       (word_q),
        .fields     (fields.producer)
    );

    logic [31:0] status_w;
    logic [31:0] ratio_w;

    // Status and ratio words built from decoded state
    always_comb
    begin
        status_w = 32'h0000_0000;
        status_w[boot_clk_pkg::ST_VALID_BIT]       = fields.valid;
        status_w[boot_clk_pkg::ST_RSVD_ERR_BIT]    = fields.rsvd_err;
        status_w[boot_clk_pkg::ST_USB_ON_BIT]      = fields.usb_on;
        status_w[boot_clk_pkg::ST_USB_PRESENT_BIT] = HAS_USB;
        ratio_w = {7'h00, fields.odiv_ratio_log, fields.usb_div_ratio, 4'h0, fields.mul_ratio, fields.in_div_sel};
    end

    av_word_slave u_bus (
        .mclk        (mclk),
        .arst_n      (arst_n),
        .address     (address),
        .read        (read),
        .write       (write),
        .readdata    (readdata),
        .waitrequest (waitrequest),
        .word0       (word_q),
        .word2       (status_w),
        .word3       (ratio_w)
    );

    // Raw fields straight from the held word, except the input divisor select taken from the decoder register and the USB bypass tied to 1 without USB
    assign pll_output_divisor_sel = word_q[boot_clk_pkg::ODIV_LSB +: 3];
    assign pll_multiplier_sel     = word_q[boot_clk_pkg::MUL_LSB +: 3];
    assign pll_input_divisor_sel  = fields.in_div_sel;
    assign usb_pll_bypass         = HAS_USB ? word_q[boot_clk_pkg::USB_BYPASS_BIT] : 1'b1;
    assign usb_pll_input_div_sel  = word_q[boot_clk_pkg::USB_IDIV_LSB +: 3];
    // Decoded ratios, registered in the decoder
    assign cfg_ready              = fields.valid;
    assign pll_mul_ratio          = fields.mul_ratio;
    assign pll_out_div_ratio      = fields.odiv_ratio_log;
    assign usb_pll_div_ratio      = fields.usb_div_ratio;
    assign usb_pll_enable         = fields.usb_on;
    assign rsvd_error             = fields.rsvd_err;

    // Checks on capture and visibility
    hold_word_a: assert property (@(posedge mclk) disable iff (!arst_n)
        captured_q |=> $stable(word_q)) else $error("captured word changed");
    ready_lag_a: assert property (@(posedge mclk) disable iff (!arst_n)
        $rose(captured_q) |=> cfg_ready) else $error("ready not one cycle after capture");
    no_usb_a: assert property (@(posedge mclk) disable iff (!arst_n)
        !HAS_USB |-> !usb_pll_enable && usb_pll_bypass) else $error("usb active on part without usb");
    rsvd_flag_a: assert property (@(posedge mclk) disable iff (!arst_n)
        captured_q && word_q[3] == 1'b0 |=> rsvd_error) else $error("reserved zero not flagged");
    cap_cov: cover property (@(posedge mclk) disable iff (!arst_n) $rose(cfg_ready));
    err_cov: cover property (@(posedge mclk) disable iff (!arst_n) rsvd_error);
    usb_cov: cover property (@(posedge mclk) disable iff (!arst_n) usb_pll_enable);
endmodule : boot_clock_cfg

//--- sim/boot_clock_cfg_tb_top.sv
// Testbench: boot clock word capture, decode and register reads
`timescale 1ns/1ps
module boot_clock_cfg_tb_top;
    logic        mclk;
    logic        arst_n;
    logic [31:0] nv_word;
    logic        nv_word_valid;
    logic [3:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [31:0] readdata;
    logic        waitrequest;
    logic        cfg_ready;
    logic [2:0]  odiv_sel, mul_sel, idiv_sel, udiv_sel;
    logic        bypass, usb_en, rsvd_err, bypass_n, usb_en_n;
    logic [4:0]  mul_r;
    logic [8:0]  odiv_r;
    logic [3:0]  udiv_r, udiv_r_n;
    int          fail_count = 0;
    int          n_compared = 0;
    int          cyc = 0;
    logic [31:0] w, d;
    // Expected ratio per code, worked out by hand
    logic [8:0]  odiv_t [8] = '{9'h001, 9'h002, 9'h004, 9'h008, 9'h010, 9'h020, 9'h040, 9'h100};
    logic [4:0]  mul_t [8]  = '{5'h0f, 5'h10, 5'h11, 5'h12, 5'h13, 5'h14, 5'h15, 5'h18};
    logic [3:0]  udiv_t [8] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'ha, 4'hc};

    // Part with the USB module, bus under test
    boot_clock_cfg #(.HAS_USB(1'b1)) boot_clock_cfg_i (
        .mclk(mclk), .arst_n(arst_n), .nv_word(nv_word), .nv_word_valid(nv_word_valid),
        .address(address), .read(read), .write(write), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest), .cfg_ready(cfg_ready),
        .pll_output_divisor_sel(odiv_sel), .pll_multiplier_sel(mul_sel),
        .pll_input_divisor_sel(idiv_sel), .usb_pll_bypass(bypass),
        .usb_pll_input_div_sel(udiv_sel), .pll_mul_ratio(mul_r), .pll_out_div_ratio(odiv_r),
        .usb_pll_div_ratio(udiv_r), .usb_pll_enable(usb_en), .rsvd_error(rsvd_err));

    // Part without USB: same word, USB enable, bypass and divider ratio must stay inert
    boot_clock_cfg #(.HAS_USB(1'b0)) boot_clock_cfg_nousb_i (
        .mclk(mclk), .arst_n(arst_n), .nv_word(nv_word), .nv_word_valid(nv_word_valid),
        .address(address), .read(read), .write(write), .writedata(writedata),
        .readdata(), .waitrequest(), .cfg_ready(), .pll_output_divisor_sel(),
        .pll_multiplier_sel(), .pll_input_divisor_sel(), .usb_pll_bypass(bypass_n),
        .usb_pll_input_div_sel(), .pll_mul_ratio(), .pll_out_div_ratio(),
        .usb_pll_div_ratio(udiv_r_n), .usb_pll_enable(usb_en_n), .rsvd_error());

    // Clock source
    initial
    begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    // Hang guard, far above the fewer than two hundred cycles the run needs
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            fail_count++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e)
        begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk

    // Bus access; request held until waitrequest is sampled low at a rising edge,
    // read data taken at that same edge; only the hang guard ends a stuck wait
    task automatic access(input logic [3:0] a, input logic rw, input logic [31:0] wd, output logic [31:0] rd_d);
        @(posedge mclk);
        address   <= a;
        read      <= ~rw;
        write     <= rw;
        writedata <= wd;
        do
        begin
            @(posedge mclk);
        end
        while (waitrequest !== 1'b0);
        rd_d  = readdata;
        read  <= 1'b0;
        write <= 1'b0;
    endtask : access

    // Short reset in mid-run, then two capture strobes with different words
    task automatic reset_capture(input logic [31:0] x);
        @(posedge mclk);
        arst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        arst_n        <= 1'b1;
        nv_word       <= x;
        nv_word_valid <= 1'b1;
        @(posedge mclk);
        // Second strobe with another word must be ignored
        nv_word       <= ~x;
        @(posedge mclk);
        nv_word_valid <= 1'b0;
        repeat (2) @(posedge mclk);
        @(negedge mclk);
    endtask : reset_capture

    task tally_and_finish;
        if (fail_count == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : tally_and_finish

    // Main sequence: every code of every field, then refusals
    initial
    begin
        arst_n        = 1'b0;
        nv_word       = 32'h0000_0000;
        nv_word_valid = 1'b0;
        address       = 4'h0;
        read          = 1'b0;
        write         = 1'b0;
        writedata     = 32'h0000_0000;
        repeat (16) @(posedge mclk);
        for (int c = 0; c < 8; c++)
        begin
            w = boot_clk_pkg::RSVD_MASK | {13'h0, c[2:0], c[0], 4'h0, c[2:0], 1'b0, c[2:0], 1'b0, c[2:0]};
            reset_capture(w);
            chk({20'h0, odiv_sel, odiv_r}, {20'h0, c[2:0], odiv_t[c]});
            chk({30'h0, bypass, usb_en}, {30'h0, c[0], ~c[0]});
            chk({25'h0, udiv_sel, udiv_r}, {25'h0, c[2:0], udiv_t[c]});
            chk({24'h0, mul_sel, mul_r}, {24'h0, c[2:0], mul_t[c]});
            chk({29'h0, idiv_sel}, {29'h0, c[2:0]});
            chk({26'h0, bypass_n, usb_en_n, udiv_r_n}, {26'h0, 1'b1, 1'b0, 4'h1});
            chk({30'h0, cfg_ready, rsvd_err}, {30'h0, 1'b1, 1'b0});
            access(4'h0, 1'b0, 32'h0, d);
            chk(d, w);
            access(4'hc, 1'b0, 32'h0, d);
            chk(d, {7'h0, odiv_t[c], udiv_t[c], 4'h0, mul_t[c], c[2:0]});
            access(4'h8, 1'b0, 32'h0, d);
            chk(d, {28'h0, 1'b1, ~c[0], 1'b0, 1'b1});
        end
        // Writes discarded, unmapped read gives zero
        access(4'h0, 1'b1, 32'h0000_0000, d);
        access(4'h0, 1'b0, 32'h0, d);
        chk(d, w);
        access(4'h4, 1'b0, 32'h0, d);
        chk(d, 32'h0000_0000);
        // A reserved position left at zero is flagged
        reset_capture(w & ~32'h0000_0008);
        chk({31'h0, rsvd_err}, 32'h0000_0001);
        access(4'h8, 1'b0, 32'h0, d);
        chk(d, 32'h0000_000b);
        tally_and_finish();
    end
endmodule : boot_clock_cfg_tb_top
